//--- pkg/debug_pin_defines.svh
`ifndef DEBUG_PIN_DEFINES_SVH
`define DEBUG_PIN_DEFINES_SVH

// ----------------------------------------------------------------
// Serial clock
// ----------------------------------------------------------------
// System clock cycles per device serial clock tick
`define SER_DIV          4
// Host assumption of the slowest serial tick, in system cycles
`define HOST_SLOW_DIV    8

// ----------------------------------------------------------------
// Device timing in serial ticks
// ----------------------------------------------------------------
`define ACK_LOW_TICKS    8'd16
`define ACK_MIN_GAP      6'd32
`define SYNC_THRESH      8'd128
`define SYNC_DELAY       8'd16
`define SYNC_RESP_TICKS  8'd128
`define SHORT_ABORT_MIN  8'd4

// ----------------------------------------------------------------
// Host timing in system cycles
// ----------------------------------------------------------------
`define HOST_SYNC_LOW    (128 * `HOST_SLOW_DIV)
`define HOST_SHORT_LOW   (8 * `SER_DIV)

`endif

//--- pkg/debug_pin_if.sv
`timescale 1ns/10ps
`default_nettype none

interface debug_pin_if;
	logic dev_drv;
	logic dev_oe_n;
	logic host_drv;
	logic host_oe_n;
	logic pin_level;

	// Wired level: pulled high, low if any side drives low
	assign pin_level = !((!dev_oe_n && !dev_drv) || (!host_oe_n && !host_drv));

	modport device (input pin_level, output dev_drv, output dev_oe_n);
	modport host   (input pin_level, output host_drv, output host_oe_n);
endinterface : debug_pin_if

`default_nettype wire

//--- pkg/debug_pin_pkg.sv
`default_nettype none

package debug_pin_pkg;

	// ------------------------------------------------------------
	// Command classes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_OTHER,
		CMD_READ,
		CMD_WRITE,
		CMD_ACK_ENABLE,
		CMD_ACK_DISABLE,
		CMD_BACKGROUND,
		CMD_GO,
		CMD_GO_UNTIL,
		CMD_SINGLE_STEP,
		CMD_TAG_AND_RUN
	} cmd_class_t;

	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		D_IDLE,
		D_LOW_CNT,
		D_SYNC_WAIT_HIGH,
		D_SYNC_DELAY,
		D_SYNC_LOW,
		D_ACK_LOW,
		D_SPEEDUP
	} dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE,
		H_LOW,
		H_SPEEDUP,
		H_LISTEN,
		H_MEASURE,
		H_ACK_LOW
	} host_state_t;

	// ------------------------------------------------------------
	// Module state records
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} tick_regs_t;

	typedef struct packed {
		dev_state_t st;
		logic [7:0] cnt;
		logic       pin_q;
		logic       hs_en;
		logic       pend;
		cmd_class_t pcls;
		logic       ev_seen;
		logic [5:0] gap;
		logic       drv;
		logic       oe_n;
		logic       soft_rst;
		logic       cancel;
		logic       ack_done;
		logic       ack_phase;
		logic       sync_busy;
	} dev_regs_t;

	typedef struct packed {
		host_state_t st;
		logic [15:0] cnt;
		logic        short_ab;
		logic        pin_q;
		logic        drv;
		logic        oe_n;
		logic        busy;
		logic        ref_valid;
		logic [15:0] ref_cycles;
		logic        ack_seen;
	} host_regs_t;

endpackage : debug_pin_pkg

`default_nettype wire

//--- rtl/debug_pin_device.sv
// Operation
// - Host abort: low 128 ticks, speedup
// - Long low: run sync, cancel pending ack
// - Short abort: cancel ack on falling edge
// - Short abort: no sync, next edge new
// - Enable and disable commands switch handshake
// - Handshake disabled after reset
// - Enable command acknowledges itself
// - Handshake off: host waits worst case
// - Read acks after bus cycle done
// - Write acks after data and bus
// - Background command acks on entering background
// - Go command acks on leaving background
// - Run-until-halt acks on next background entry
// - Single step acks on background re-entry
// - Tag-and-run never acknowledges
// - Host sync: long low, speedup, listen
// - Sync: discard, await high, wait 16
// - Drive low 128, speedup, release
// - Host measures response low time
// - After sync next edge starts anew
// - Known rate: abort just over 128
// - Ack is 16 ticks low plus speedup
// - Ack no sooner than 32 ticks after
`timescale 1ns/10ps
`default_nettype none

`include "debug_pin_defines.svh"

module debug_pin_device
	import debug_pin_pkg::*;
#(
	parameter int SER_DIV = `SER_DIV
)(
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	debug_pin_if.device      pin,
	input  wire logic        i_cmd_done,
	input  wire cmd_class_t  i_cmd_class,
	input  wire logic        i_bus_done,
	input  wire logic        i_cpu_enter_bg,
	input  wire logic        i_cpu_exit_bg,
	output logic             o_handshake_en,
	output logic             o_ack_pending,
	output logic             o_ack_done,
	output logic             o_cmd_cancel,
	output logic             o_soft_reset,
	output logic             o_sync_busy
);

	// ------------------------------------------------------------
	// Serial tick
	// ------------------------------------------------------------
	logic tick;

	serial_tick_gen #(
		.DIV (SER_DIV)
	) u_tick (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.o_tick    (tick)
	);

	// ------------------------------------------------------------
	// Completion event per command class
	// ------------------------------------------------------------
	function automatic logic ev_match(
		input cmd_class_t cls,
		input logic       bus,
		input logic       enter,
		input logic       leave
	);
		logic m;
		m = 1'b0;
		case (cls)
			CMD_READ:        m = bus;
			CMD_WRITE:       m = bus;
			CMD_BACKGROUND:  m = enter;
			CMD_GO:          m = leave;
			CMD_GO_UNTIL:    m = enter;
			CMD_SINGLE_STEP: m = enter;
			default:         m = 1'b0;
		endcase
		return m;
	endfunction : ev_match

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	dev_regs_t r_r;
	dev_regs_t r_nxt;
	logic      pin_now;
	logic      fall;

	assign pin_now = pin.pin_level;
	assign fall    = r_r.pin_q && !pin_now;

	always_comb
	begin
		r_nxt          = r_r;
		r_nxt.soft_rst = 1'b0;
		r_nxt.cancel   = 1'b0;
		r_nxt.ack_done = 1'b0;

		// Command completion from the command engine
		if (i_cmd_done)
		begin
			r_nxt.pcls    = i_cmd_class;
			r_nxt.gap     = 6'h00;
			r_nxt.ev_seen = 1'b0;
			case (i_cmd_class)
				CMD_ACK_ENABLE:
				begin
					r_nxt.hs_en   = 1'b1;
					r_nxt.pend    = 1'b1;
					r_nxt.ev_seen = 1'b1;
				end
				CMD_ACK_DISABLE:
				begin
					r_nxt.hs_en = 1'b0;
					r_nxt.pend  = 1'b0;
				end
				CMD_TAG_AND_RUN:
					r_nxt.pend = 1'b0;
				CMD_OTHER:
					r_nxt.pend = r_r.pend;
				default:
					r_nxt.pend = r_r.hs_en;
			endcase
		end
		else if (r_r.pend && !r_r.ev_seen
			&& ev_match(r_r.pcls, i_bus_done, i_cpu_enter_bg, i_cpu_exit_bg))
		begin
			r_nxt.ev_seen = 1'b1;
		end

		// Serial tick domain work
		if (tick)
		begin
			r_nxt.pin_q = pin_now;
			if (r_r.pend && !i_cmd_done && r_r.gap != `ACK_MIN_GAP)
				r_nxt.gap = r_r.gap + 6'h01;

			case (r_r.st)
				D_IDLE:
				begin
					if (fall)
					begin
						r_nxt.st  = D_LOW_CNT;
						r_nxt.cnt = 8'h01;
						if (r_r.pend)
						begin
							r_nxt.pend   = 1'b0;
							r_nxt.cancel = 1'b1;
						end
					end
					else if (r_r.pend && r_r.ev_seen && !i_cmd_done
						&& r_r.gap == `ACK_MIN_GAP && pin_now)
					begin
						r_nxt.st   = D_ACK_LOW;
						r_nxt.cnt  = 8'h00;
						r_nxt.drv  = 1'b0;
						r_nxt.oe_n = 1'b0;
						r_nxt.pend = 1'b0;
					end
				end
				D_LOW_CNT:
				begin
					if (pin_now)
						r_nxt.st = D_IDLE;
					else if (r_r.cnt == `SYNC_THRESH - 8'h01)
					begin
						r_nxt.st        = D_SYNC_WAIT_HIGH;
						r_nxt.soft_rst  = 1'b1;
						r_nxt.pend      = 1'b0;
						r_nxt.sync_busy = 1'b1;
					end
					else
						r_nxt.cnt = r_r.cnt + 8'h01;
				end
				D_SYNC_WAIT_HIGH:
				begin
					if (pin_now)
					begin
						r_nxt.st  = D_SYNC_DELAY;
						r_nxt.cnt = 8'h00;
					end
				end
				D_SYNC_DELAY:
				begin
					if (r_r.cnt == `SYNC_DELAY - 8'h01)
					begin
						r_nxt.st   = D_SYNC_LOW;
						r_nxt.cnt  = 8'h00;
						r_nxt.drv  = 1'b0;
						r_nxt.oe_n = 1'b0;
					end
					else
						r_nxt.cnt = r_r.cnt + 8'h01;
				end
				D_SYNC_LOW:
				begin
					if (r_r.cnt == `SYNC_RESP_TICKS - 8'h01)
					begin
						r_nxt.st        = D_SPEEDUP;
						r_nxt.drv       = 1'b1;
						r_nxt.ack_phase = 1'b0;
					end
					else
						r_nxt.cnt = r_r.cnt + 8'h01;
				end
				D_ACK_LOW:
				begin
					if (r_r.cnt == `ACK_LOW_TICKS - 8'h01)
					begin
						r_nxt.st        = D_SPEEDUP;
						r_nxt.drv       = 1'b1;
						r_nxt.ack_phase = 1'b1;
					end
					else
						r_nxt.cnt = r_r.cnt + 8'h01;
				end
				D_SPEEDUP:
				begin
					r_nxt.st        = D_IDLE;
					r_nxt.drv       = 1'b0;
					r_nxt.oe_n      = 1'b1;
					r_nxt.pin_q     = 1'b1;
					r_nxt.sync_busy = 1'b0;
					r_nxt.ack_done  = r_r.ack_phase;
				end
				default:
					r_nxt.st = D_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r_r       <= '0;
			r_r.st    <= D_IDLE;
			r_r.pin_q <= 1'b1;
			r_r.oe_n  <= 1'b1;
			r_r.pcls  <= CMD_OTHER;
		end
		else
			r_r <= r_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign pin.dev_drv     = r_r.drv;
	assign pin.dev_oe_n    = r_r.oe_n;
	assign o_handshake_en  = r_r.hs_en;
	assign o_ack_pending   = r_r.pend;
	assign o_ack_done      = r_r.ack_done;
	assign o_cmd_cancel    = r_r.cancel;
	assign o_soft_reset    = r_r.soft_rst;
	assign o_sync_busy     = r_r.sync_busy;

endmodule : debug_pin_device

`default_nettype wire

//--- rtl/debug_pin_host.sv
`timescale 1ns/10ps
`default_nettype none

`include "debug_pin_defines.svh"

module debug_pin_host
	import debug_pin_pkg::*;
#(
	parameter int SYNC_LOW_CYCLES  = `HOST_SYNC_LOW,
	parameter int SHORT_LOW_CYCLES = `HOST_SHORT_LOW
)(
	input  wire logic   i_sys_clk,
	input  wire logic   i_arst_n,
	debug_pin_if.host   pin,
	input  wire logic   i_sync_req,
	input  wire logic   i_short_abort,
	output logic        o_busy,
	output logic        o_ref_valid,
	output logic [15:0] o_ref_cycles,
	output logic        o_ack_seen
);

	host_regs_t r_r;
	host_regs_t r_nxt;
	logic       pin_now;
	logic       fall;

	assign pin_now = pin.pin_level;
	assign fall    = r_r.pin_q && !pin_now;

	always_comb
	begin
		r_nxt           = r_r;
		r_nxt.pin_q     = pin_now;
		r_nxt.ref_valid = 1'b0;
		r_nxt.ack_seen  = 1'b0;
		case (r_r.st)
			H_IDLE:
			begin
				if (i_sync_req)
				begin
					r_nxt.st       = H_LOW;
					r_nxt.cnt      = 16'(SYNC_LOW_CYCLES - 1);
					r_nxt.short_ab = 1'b0;
					r_nxt.drv      = 1'b0;
					r_nxt.oe_n     = 1'b0;
					r_nxt.busy     = 1'b1;
				end
				else if (i_short_abort)
				begin
					r_nxt.st       = H_LOW;
					r_nxt.cnt      = 16'(SHORT_LOW_CYCLES - 1);
					r_nxt.short_ab = 1'b1;
					r_nxt.drv      = 1'b0;
					r_nxt.oe_n     = 1'b0;
					r_nxt.busy     = 1'b1;
				end
				else if (fall)
				begin
					r_nxt.st  = H_ACK_LOW;
					r_nxt.cnt = 16'h0001;
				end
			end
			H_LOW:
			begin
				if (r_r.cnt != 16'h0000)
					r_nxt.cnt = r_r.cnt - 16'h0001;
				else if (r_r.short_ab)
				begin
					r_nxt.st   = H_IDLE;
					r_nxt.oe_n = 1'b1;
					r_nxt.busy = 1'b0;
				end
				else
				begin
					r_nxt.st  = H_SPEEDUP;
					r_nxt.drv = 1'b1;
				end
			end
			H_SPEEDUP:
			begin
				r_nxt.st   = H_LISTEN;
				r_nxt.drv  = 1'b0;
				r_nxt.oe_n = 1'b1;
			end
			H_LISTEN:
			begin
				if (fall)
				begin
					r_nxt.st  = H_MEASURE;
					r_nxt.cnt = 16'h0001;
				end
			end
			H_MEASURE:
			begin
				if (pin_now)
				begin
					r_nxt.st         = H_IDLE;
					r_nxt.ref_cycles = r_r.cnt;
					r_nxt.ref_valid  = 1'b1;
					r_nxt.busy       = 1'b0;
				end
				else if (r_r.cnt != 16'hffff)
					r_nxt.cnt = r_r.cnt + 16'h0001;
			end
			H_ACK_LOW:
			begin
				if (pin_now)
				begin
					r_nxt.st       = H_IDLE;
					r_nxt.ack_seen = 1'b1;
				end
			end
			default:
				r_nxt.st = H_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r_r       <= '0;
			r_r.st    <= H_IDLE;
			r_r.pin_q <= 1'b1;
			r_r.oe_n  <= 1'b1;
		end
		else
			r_r <= r_nxt;
	end

	assign pin.host_drv  = r_r.drv;
	assign pin.host_oe_n = r_r.oe_n;
	assign o_busy        = r_r.busy;
	assign o_ref_valid   = r_r.ref_valid;
	assign o_ref_cycles  = r_r.ref_cycles;
	assign o_ack_seen    = r_r.ack_seen;

endmodule : debug_pin_host

`default_nettype wire

//--- rtl/serial_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none

`include "debug_pin_defines.svh"

module serial_tick_gen
	import debug_pin_pkg::*;
#(
	parameter int DIV = `SER_DIV
)(
	input  wire logic i_sys_clk,
	input  wire logic i_arst_n,
	output logic      o_tick
);

	tick_regs_t r_r;
	tick_regs_t r_nxt;

	always_comb
	begin
		r_nxt      = r_r;
		r_nxt.tick = 1'b0;
		if (r_r.cnt == 8'(DIV - 1))
		begin
			r_nxt.cnt  = 8'h00;
			r_nxt.tick = 1'b1;
		end
		else
		begin
			r_nxt.cnt = r_r.cnt + 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign o_tick = r_r.tick;

endmodule : serial_tick_gen

`default_nettype wire

//--- tb/debug_pin_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module debug_pin_assertions #(
	parameter int SYNC_LOW_CYCLES  = 600,
	parameter int SHORT_LOW_CYCLES = 32
)(
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic dev_drv,
	input wire logic dev_oe_n,
	input wire logic host_drv,
	input wire logic host_oe_n,
	input wire logic pin_level
);
	// ------------------------------------------------------------
	// Low and high run counters
	// ------------------------------------------------------------
	logic [9:0]  dlow_r;
	logic [15:0] hlow_r;
	logic [7:0]  high_r;

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			dlow_r <= 10'h0;
			hlow_r <= 16'h0;
			high_r <= 8'h0;
		end
		else
		begin
			dlow_r <= dev_oe_n ? 10'h0 : dlow_r + {9'h0, !dev_drv};
			hlow_r <= host_oe_n ? 16'h0 : hlow_r + {15'h0, !host_drv};
			high_r <= !pin_level ? 8'h0 : high_r + {7'h0, high_r != 8'hff};
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	a_reset_released: assert property ($rose(i_arst_n) |-> dev_oe_n && host_oe_n)
		else $error("pin driven after reset");
	a_dev_low_len: assert property (!dev_oe_n && dev_drv && !$past(dev_drv)
		|-> dlow_r == 10'd64 || dlow_r == 10'd512)
		else $error("device low drive length wrong");
	a_dev_speedup: assert property ($rose(dev_drv) && !dev_oe_n
		|-> (!dev_oe_n && dev_drv) [*4] ##1 (dev_oe_n && !dev_drv))
		else $error("device speedup not one tick");
	a_sync_quiet: assert property ($fell(dev_oe_n) |-> high_r >= 8'd60)
		else $error("device drove too soon after high");
	a_sync_answer: assert property (!host_oe_n && host_drv
		|-> ##[60:80] (!dev_oe_n && !dev_drv))
		else $error("no timed response");
	a_host_speedup: assert property (!host_oe_n && host_drv |=> host_oe_n && !host_drv)
		else $error("host speedup not one cycle");
	a_host_sync_len: assert property (!host_oe_n && host_drv
		|-> hlow_r == 16'(SYNC_LOW_CYCLES))
		else $error("host long low length wrong");
	a_host_short_len: assert property ($rose(host_oe_n) && !$past(host_drv)
		|-> hlow_r == 16'(SHORT_LOW_CYCLES))
		else $error("host short low length wrong");
	a_short_no_sync: assert property ($rose(host_oe_n) && !$past(host_drv) |-> dev_oe_n [*8])
		else $error("device drove after short abort");
endmodule : debug_pin_assertions

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import debug_pin_pkg::*;
();
	localparam int SER_DIV = 4;
	localparam int TICK    = 10 * SER_DIV;

	logic        i_sys_clk = 1'b0;
	logic        i_arst_n  = 1'b0;
	logic        cmd_done  = 1'b0;
	cmd_class_t  cmd_class = CMD_OTHER;
	logic [2:0]  evt       = 3'h0;
	logic        sync_req  = 1'b0;
	logic        short_ab  = 1'b0;
	logic        hs_en, ack_pend, ack_done, cancel, soft_rst, sync_busy;
	logic        busy, ref_valid, ack_seen;
	logic [15:0] ref_cycles;
	int          failures  = 0;
	int          checked   = 0;
	int          n_ack     = 0;
	int          n_cancel  = 0;
	int          n_soft    = 0;
	int          n_ref     = 0;
	int          n_seen    = 0;
	int          n_busy    = 0;
	time         t_cmd, t_drive;
	cmd_class_t  acks[6]   = '{CMD_READ, CMD_WRITE, CMD_BACKGROUND, CMD_GO,
		CMD_GO_UNTIL, CMD_SINGLE_STEP};

	always #5 i_sys_clk = ~i_sys_clk;

	debug_pin_if pin_if();

	debug_pin_device #(.SER_DIV(SER_DIV)) u_debug_pin_device (
		.i_sys_clk      (i_sys_clk),
		.i_arst_n       (i_arst_n),
		.pin            (pin_if),
		.i_cmd_done     (cmd_done),
		.i_cmd_class    (cmd_class),
		.i_bus_done     (evt[0]),
		.i_cpu_enter_bg (evt[1]),
		.i_cpu_exit_bg  (evt[2]),
		.o_handshake_en (hs_en),
		.o_ack_pending  (ack_pend),
		.o_ack_done     (ack_done),
		.o_cmd_cancel   (cancel),
		.o_soft_reset   (soft_rst),
		.o_sync_busy    (sync_busy)
	);

	debug_pin_host #(.SYNC_LOW_CYCLES(600), .SHORT_LOW_CYCLES(32)) u_debug_pin_host (
		.i_sys_clk     (i_sys_clk),
		.i_arst_n      (i_arst_n),
		.pin           (pin_if),
		.i_sync_req    (sync_req),
		.i_short_abort (short_ab),
		.o_busy        (busy),
		.o_ref_valid   (ref_valid),
		.o_ref_cycles  (ref_cycles),
		.o_ack_seen    (ack_seen)
	);

	debug_pin_assertions #(.SYNC_LOW_CYCLES(600), .SHORT_LOW_CYCLES(32)) chk (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.dev_drv   (pin_if.dev_drv),
		.dev_oe_n  (pin_if.dev_oe_n),
		.host_drv  (pin_if.host_drv),
		.host_oe_n (pin_if.host_oe_n),
		.pin_level (pin_if.pin_level)
	);

	// ------------------------------------------------------------
	// Pulse monitors
	// ------------------------------------------------------------
	always @(negedge i_sys_clk)
	begin
		n_ack    += int'(ack_done === 1'b1);
		n_cancel += int'(cancel === 1'b1);
		n_soft   += int'(soft_rst === 1'b1);
		n_ref    += int'(ref_valid === 1'b1);
		n_seen   += int'(ack_seen === 1'b1);
		n_busy   += int'(sync_busy === 1'b1);
	end

	always @(negedge pin_if.dev_oe_n) t_drive = $time;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic check(input bit ok, input string msg);
		checked++;
		if (!ok)
		begin
			failures++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check

	function automatic int ack_evt(input cmd_class_t c);
		case (c)
			CMD_READ, CMD_WRITE: return 0;
			CMD_GO:              return 2;
			default:             return 1;
		endcase
	endfunction : ack_evt

	task automatic send_cmd(input cmd_class_t c);
		@(negedge i_sys_clk);
		cmd_done  = 1'b1;
		cmd_class = c;
		t_cmd     = $time;
		@(negedge i_sys_clk);
		cmd_done  = 1'b0;
	endtask : send_cmd

	task automatic fire(input int e);
		@(negedge i_sys_clk);
		evt[e] = 1'b1;
		@(negedge i_sys_clk);
		evt    = 3'h0;
	endtask : fire

	task automatic expect_ack(input bit want, input int span, input string msg);
		int a;
		a = n_ack;
		for (int k = 0; k < span && n_ack == a; k++)
			@(negedge i_sys_clk);
		check((n_ack != a) == want, msg);
	endtask : expect_ack

	task automatic host_op(input bit sync);
		@(negedge i_sys_clk);
		sync_req = sync;
		short_ab = !sync;
		@(negedge i_sys_clk);
		sync_req = 1'b0;
		short_ab = 1'b0;
		for (int k = 0; k < 3000 && busy !== 1'b0; k++)
			@(negedge i_sys_clk);
		repeat (4) @(negedge i_sys_clk);
		check(busy === 1'b0, "host stuck busy");
	endtask : host_op

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		cmd_class_t c;
		int         e;
		int         a;
		int         b;
		int         d;
		void'($urandom(85));
		repeat (2) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_arst_n = 1'b1;
		check(hs_en === 1'b0 && ack_pend === 1'b0, "reset state");
		repeat (6)
		begin
			c = cmd_class_t'($urandom_range(9));
			if (c == CMD_ACK_ENABLE)
				c = CMD_OTHER;
			send_cmd(c);
			fire($urandom_range(2));
			expect_ack(1'b0, 250, "ack while off");
		end
		a = n_seen;
		send_cmd(CMD_ACK_ENABLE);
		check(hs_en === 1'b1 && ack_pend === 1'b1, "enable lost");
		expect_ack(1'b1, 400, "enable not acked");
		check(t_drive - t_cmd >= 32 * TICK, "ack too early");
		check(n_seen == a + 1, "host missed ack");
		foreach (acks[i])
		begin
			e = ack_evt(acks[i]);
			send_cmd(acks[i]);
			fire((e + 1) % 3);
			expect_ack(1'b0, 200, "early ack");
			fire(e);
			expect_ack(1'b1, 120, "ack missing");
		end
		send_cmd(CMD_TAG_AND_RUN);
		for (e = 0; e < 3; e++)
			fire(e);
		expect_ack(1'b0, 300, "tag-and-run acked");
		send_cmd(CMD_READ);
		a = n_cancel;
		b = n_soft;
		host_op(1'b0);
		check(n_cancel == a + 1 && n_soft == b, "short abort");
		fire(0);
		expect_ack(1'b0, 300, "ack after short abort");
		send_cmd(CMD_WRITE);
		fire(0);
		expect_ack(1'b1, 400, "no ack after abort");
		send_cmd(CMD_READ);
		a = n_soft;
		b = n_ref;
		d = n_busy;
		host_op(1'b1);
		check(n_soft == a + 1 && n_ref == b + 1, "sync missing");
		check(sync_busy === 1'b0 && n_busy - d > (16 + 128) * SER_DIV, "sync busy span");
		check(ref_cycles >= 16'(127 * SER_DIV) && ref_cycles <= 16'(129 * SER_DIV),
			"reference length");
		fire(0);
		expect_ack(1'b0, 300, "ack after sync");
		send_cmd(CMD_ACK_ENABLE);
		expect_ack(1'b1, 400, "no ack after sync");
		send_cmd(CMD_ACK_DISABLE);
		check(hs_en === 1'b0, "disable lost");
		expect_ack(1'b0, 300, "disable acked");
		finish_test();
	end

	initial
	begin
		#500us;
		failures++;
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
